// ==== design/ppec_params.svh ====
// constants for the peripheral power enable control block
// Overview of operation
// - only power-on reset loads the register's reset value
// - bit 7 resets 1, amp off
// - bit 4 resets 0, monitors enabled
// - low-voltage detector follows bit 4 only
// - brownout also uses always-on option bit
// - always-on option keeps brownout on, except while system reset clears the enables
// - option clear: brownout off in stop
// - option clear, active/halt: brownout follows bit
// - bit 3 resets 0, temp sensor on
// - bit 1 resets 0, comparator one on
// - bit 0 resets 0, comparator two on
// - set disable bit shuts its block down, except brownout with always-on option
// - stop mode entered by stop instruction
`ifndef PPEC_PARAMS_SVH
`define PPEC_PARAMS_SVH
`define PPEC_OFS_DISABLE   12'h0F80
`define PPEC_RST_DISABLE   8'h80
`define PPEC_BIT_AMP       7
`define PPEC_BIT_MON       4
`define PPEC_BIT_TEMP      3
`define PPEC_BIT_CMP0      1
`define PPEC_BIT_CMP1      0
`define PPEC_RSVD_MASK     8'h64
`endif

// ==== design/ppec_pkg.sv ====
// types for the peripheral power enable control block
package ppec_pkg;
  typedef logic [11:0] ppec_addr_t;
  typedef logic [7:0]  ppec_data_t;
  typedef enum logic [2:0] {
    PPEC_ACTIVE = 3'b001,
    PPEC_HALT   = 3'b010,
    PPEC_STOP   = 3'b100
  } ppec_mode_t;
  typedef struct packed {
    logic amp_en;
    logic lvd_en;
    logic bod_en;
    logic temp_en;
    logic cmp0_en;
    logic cmp1_en;
  } ppec_en_t;
endpackage : ppec_pkg

// ==== design/ppec_en_if.sv ====
// carrier between register file and enable decoder
`timescale 1ns/1ps
interface ppec_en_if;
  import ppec_pkg::*;
  ppec_data_t disable_bits;
  logic       always_on;
  logic       in_stop;
  ppec_en_t   en;
  modport regs (output disable_bits, output always_on, output in_stop, input en);
  modport dec  (input disable_bits, input always_on, input in_stop, output en);
endinterface : ppec_en_if

// ==== design/ppec_decode.sv ====
// combinational enable decoder
`timescale 1ns/1ps
`include "ppec_params.svh"
module ppec_decode (
  ppec_en_if.dec bus
);
  import ppec_pkg::*;
  always_comb begin
    bus.en.amp_en  = ~bus.disable_bits[`PPEC_BIT_AMP];
    bus.en.lvd_en  = ~bus.disable_bits[`PPEC_BIT_MON];
    if (bus.always_on) begin
      bus.en.bod_en = 1'b1;
    end else if (bus.in_stop) begin
      bus.en.bod_en = 1'b0;
    end else begin
      bus.en.bod_en = ~bus.disable_bits[`PPEC_BIT_MON];
    end
    bus.en.temp_en = ~bus.disable_bits[`PPEC_BIT_TEMP];
    bus.en.cmp0_en = ~bus.disable_bits[`PPEC_BIT_CMP0];
    bus.en.cmp1_en = ~bus.disable_bits[`PPEC_BIT_CMP1];
  end
endmodule : ppec_decode

// ==== design/ppec_top.sv ====
// peripheral power enable control: wishbone register and enables
`timescale 1ns/1ps
`include "ppec_params.svh"
module ppec_top (
  input  wire logic                i_clk,
  input  wire logic                i_rst_n,
  input  wire logic                i_por_n,
  input  wire logic                i_cyc,
  input  wire logic                i_stb,
  input  wire logic                i_we,
  input  wire logic [3:0]          i_sel,
  input  wire ppec_pkg::ppec_addr_t i_adr,
  input  wire logic [31:0]         i_dat,
  output logic      [31:0]         o_dat,
  output logic                     o_ack,
  input  wire logic                i_always_on_opt,
  input  wire ppec_pkg::ppec_mode_t i_mode,
  output logic                     o_amp_en,
  output logic                     o_lvd_en,
  output logic                     o_bod_en,
  output logic                     o_temp_en,
  output logic                     o_cmp0_en,
  output logic                     o_cmp1_en
);
  import ppec_pkg::*;

  // power-on reset loads the register; the system reset clears the ack, read data and registered enables
  typedef struct packed {
    logic       ack;
    logic [7:0] dat;
    ppec_en_t   en;
  } ppec_bus_t;

  logic [1:0] rst_sync_r;
  logic [1:0] por_sync_r;
  logic       rst_n;
  logic       por_n;
  ppec_data_t dis_r;
  ppec_data_t dis_nxt;
  ppec_bus_t  st_r;
  ppec_bus_t  st_nxt;
  logic       hit;
  logic       acc;

  ppec_en_if en_bus ();

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rst_sync_r <= 2'b00;
    end else begin
      rst_sync_r <= {rst_sync_r[0], 1'b1};
    end
  end
  always_ff @(posedge i_clk or negedge i_por_n) begin
    if (!i_por_n) begin
      por_sync_r <= 2'b00;
    end else begin
      por_sync_r <= {por_sync_r[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_r[1];
  assign por_n = por_sync_r[1];

  assign acc = i_cyc && i_stb && !st_r.ack;
  assign hit = (i_adr == `PPEC_OFS_DISABLE);

  // register held across all resets but power-on
  always_comb begin
    dis_nxt = dis_r;
    if (acc && i_we && hit && i_sel[0]) begin
      dis_nxt = i_dat[7:0];
    end
  end
  always_ff @(posedge i_clk or negedge por_n) begin
    if (!por_n) begin
      dis_r <= `PPEC_RST_DISABLE;
    end else begin
      dis_r <= dis_nxt;
    end
  end

  assign en_bus.disable_bits = dis_r;
  assign en_bus.always_on    = i_always_on_opt;
  assign en_bus.in_stop      = (i_mode == PPEC_STOP);

  ppec_decode u_dec (
    .bus (en_bus.dec)
  );

  always_comb begin
    st_nxt     = st_r;
    st_nxt.ack = acc;
    st_nxt.dat = (acc && !i_we && hit) ? dis_r : 8'h00;
    st_nxt.en  = en_bus.en;
  end
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign o_ack     = st_r.ack;
  assign o_dat     = {24'h00_0000, st_r.dat};
  assign o_amp_en  = st_r.en.amp_en;
  assign o_lvd_en  = st_r.en.lvd_en;
  assign o_bod_en  = st_r.en.bod_en;
  assign o_temp_en = st_r.en.temp_en;
  assign o_cmp0_en = st_r.en.cmp0_en;
  assign o_cmp1_en = st_r.en.cmp1_en;

  a_bod_always_on: assert property (@(posedge i_clk) disable iff (!rst_n)
    i_always_on_opt |=> o_bod_en) else $error("brownout off with always-on");
  a_bod_stop_off: assert property (@(posedge i_clk) disable iff (!rst_n)
    (!i_always_on_opt && i_mode == PPEC_STOP) |=> !o_bod_en) else $error("brownout on in stop");
  a_bod_active: assert property (@(posedge i_clk) disable iff (!rst_n)
    (!i_always_on_opt && i_mode != PPEC_STOP) |=> (o_bod_en == !$past(dis_r[4])))
    else $error("brownout not following bit");
  a_lvd_follow: assert property (@(posedge i_clk) disable iff (!rst_n)
    1'b1 |=> (o_lvd_en == !$past(dis_r[4]))) else $error("lvd mismatch");
  a_amp_follow: assert property (@(posedge i_clk) disable iff (!rst_n)
    1'b1 |=> (o_amp_en == !$past(dis_r[7]))) else $error("amp mismatch");
  a_temp_follow: assert property (@(posedge i_clk) disable iff (!rst_n)
    1'b1 |=> (o_temp_en == !$past(dis_r[3]))) else $error("temp mismatch");
  a_cmp0_follow: assert property (@(posedge i_clk) disable iff (!rst_n)
    1'b1 |=> (o_cmp0_en == !$past(dis_r[1]))) else $error("cmp0 mismatch");
  a_cmp1_follow: assert property (@(posedge i_clk) disable iff (!rst_n)
    1'b1 |=> (o_cmp1_en == !$past(dis_r[0]))) else $error("cmp1 mismatch");
  a_hold_no_wr: assert property (@(posedge i_clk) disable iff (!por_n)
    !(i_cyc && i_stb && i_we) |=> $stable(dis_r)) else $error("register changed");
endmodule : ppec_top

// ==== sim/test_ppec_top.sv ====
// self-checking bench for the peripheral power enable control block
`timescale 1ns/1ps
`include "ppec_params.svh"
module test_ppec_top;
  import ppec_pkg::*;
  logic        clk, rst_n, por_n, cyc, stb, we, opt, ack;
  logic        amp, low_voltage_detector, bod, temp, c0, c1;
  logic [3:0]  sel;
  logic [31:0] dat, odat, rd;
  ppec_addr_t  adr;
  ppec_mode_t  mode;
  int          n_mismatch, checks_done;
  ppec_top DUT (.i_clk(clk), .i_rst_n(rst_n), .i_por_n(por_n), .i_cyc(cyc), .i_stb(stb),
    .i_we(we), .i_sel(sel), .i_adr(adr), .i_dat(dat), .o_dat(odat), .o_ack(ack),
    .i_always_on_opt(opt), .i_mode(mode), .o_amp_en(amp), .o_lvd_en(low_voltage_detector), .o_bod_en(bod),
    .o_temp_en(temp), .o_cmp0_en(c0), .o_cmp1_en(c1));
  task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  // one classic cycle; waits for ack under a bounded count
  task automatic wb(logic w, ppec_addr_t a, logic [7:0] d);
    int n;
    n = 0;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we  <= w;
    adr <= a;
    dat <= {24'h00_0000, d};
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 20);
    rd = odat;
    chk("ack", 32'h1, {31'h0, ack});
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk);
  endtask : wb
  // expected enables worked out from the register, the always-on option and the mode
  task automatic chk_en(logic [7:0] r);
    logic [5:0] e;
    repeat (3) @(posedge clk);
    e = {~r[7], ~r[4], opt | (~r[4] & (mode != PPEC_STOP)), ~r[3], ~r[1], ~r[0]};
    chk("enables", {26'h0, e}, {26'h0, amp, low_voltage_detector, bod, temp, c0, c1});
  endtask : chk_en
  task automatic reg_is(logic [7:0] r);
    wb(1'b0, `PPEC_OFS_DISABLE, 8'h00);
    chk("register", {24'h0, r}, rd);
  endtask : reg_is
  task automatic t_bits();
    logic [7:0] v[6] = '{8'h80, 8'h10, 8'h08, 8'h02, 8'h01, 8'h00};
    foreach (v[i]) begin
      wb(1'b1, `PPEC_OFS_DISABLE, v[i]);
      reg_is(v[i]);
      chk_en(v[i]);
    end
    mode <= PPEC_STOP;
    chk_en(8'h00);
    mode <= PPEC_ACTIVE;
    $display("test bits done");
  endtask : t_bits
  task automatic t_monitor();
    ppec_mode_t m[3] = '{PPEC_ACTIVE, PPEC_HALT, PPEC_STOP};
    for (int o = 0; o < 2; o++) begin
      for (int b = 0; b < 2; b++) begin
        wb(1'b1, `PPEC_OFS_DISABLE, b ? 8'h10 : 8'h00);
        foreach (m[k]) begin
          opt  <= o[0];
          mode <= m[k];
          chk_en(b ? 8'h10 : 8'h00);
        end
      end
    end
    opt  <= 1'b0;
    mode <= PPEC_ACTIVE;
    $display("test monitor done");
  endtask : t_monitor
  task automatic t_bus();
    wb(1'b1, `PPEC_OFS_DISABLE, 8'h9B);
    wb(1'b0, 12'hF81, 8'h00);
    chk("unmapped read", 32'h0, rd);
    wb(1'b1, 12'hF81, 8'h00);
    sel <= 4'h0;
    wb(1'b1, `PPEC_OFS_DISABLE, 8'h00);
    sel <= 4'h1;
    reg_is(8'h9B);
    $display("test bus done");
  endtask : t_bus
  task automatic t_resets();
    rst_n <= 1'b0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
    reg_is(8'h9B);
    chk_en(8'h9B);
    por_n <= 1'b0;
    repeat (3) @(posedge clk);
    por_n <= 1'b1;
    repeat (4) @(posedge clk);
    reg_is(`PPEC_RST_DISABLE);
    $display("test resets done");
  endtask : t_resets
  task automatic finish_test();
    $display("mismatches %0d of %0d checks", n_mismatch, checks_done);
    if (n_mismatch == 0 && checks_done > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : finish_test
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // whole run is under two hundred cycles; this span of 5000 cycles is generous
  initial begin
    #(25 * 5000);
    n_mismatch++;
    finish_test();
  end
  initial begin
    {rst_n, por_n, cyc, stb, we, opt} = 6'h00;
    sel  = 4'h1;
    adr  = 12'h000;
    dat  = 32'h0000_0000;
    mode = PPEC_ACTIVE;
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    por_n <= 1'b1;
    repeat (4) @(posedge clk);
    reg_is(`PPEC_RST_DISABLE);
    chk_en(`PPEC_RST_DISABLE);
    t_bits();
    t_monitor();
    t_bus();
    t_resets();
    finish_test();
  end
endmodule : test_ppec_top
